// [dlf_pkg.sv]
// dlf_pkg: shared constants and types of the dll mode tracker
package dlf_pkg;
    // ========================================================
    // register map and reset values
    localparam logic [7:0]  DLF_LOCK_CFG_OFS = 8'h00;
    localparam logic [7:0]  DLF_STATUS_OFS   = 8'h04;
    localparam logic [7:0]  DLF_HOLD_CFG_OFS = 8'h08;
    localparam logic [7:0]  DLF_MR_BASE_OFS  = 8'h10;
    localparam logic [15:0] DLF_LOCK_CYC_RST = 16'h0200;
    localparam logic [15:0] DLF_HOLD_CYC_RST = 16'h0005;
    localparam logic [1:0]  DLF_RESP_OK      = 2'h0;
    localparam logic [1:0]  DLF_RESP_SLVERR  = 2'h2;
    // ========================================================
    // mode register fields
    localparam int          DLF_MR1_DLL_DIS  = 0;
    localparam int          DLF_MR0_DLL_RST  = 8;
    localparam int          DLF_MR0_CL_LSB   = 4;
    localparam int          DLF_MR2_CWL_LSB  = 3;
    localparam int          DLF_MR1_AL_LSB   = 3;
    localparam logic [4:0]  DLF_CL_BIAS      = 5'h04;
    localparam logic [4:0]  DLF_CWL_BIAS     = 5'h05;
    localparam logic [4:0]  DLF_OFF_CL       = 5'h06;
    localparam logic [4:0]  DLF_OFF_CWL      = 5'h06;
    localparam logic [12:0] DLF_MR0_RST      = 13'h0020;
    localparam logic [12:0] DLF_MR_RST       = 13'h0000;
    // ========================================================
    // types
    typedef enum logic [1:0] {
        DLF_OFF      = 2'b00,
        DLF_UNLOCKED = 2'b01,
        DLF_LOCKING  = 2'b10,
        DLF_LOCKED   = 2'b11
    } dlf_dll_state_t;

    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  ba;
        logic [12:0] addr;
        logic        cke;
        logic        termination_control_pin;
    } dlf_pins_t;
endpackage : dlf_pkg

// [dlf_mode_mem.sv]
// dlf_mode_mem: four mode register words with registered read port
`timescale 1ns/100ps
`default_nettype none
module dlf_mode_mem
    import dlf_pkg::*;
#(
    parameter int WIDTH = 13
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             wr_en,
    input  wire logic [1:0]       wr_idx,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [1:0]       rd_idx,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_r [4];
    logic [WIDTH-1:0] rd_r;

    // ========================================================
    // storage, reset to power-up mode values
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_r[0] <= WIDTH'(DLF_MR0_RST);
            mem_r[1] <= WIDTH'(DLF_MR_RST);
            mem_r[2] <= WIDTH'(DLF_MR_RST);
            mem_r[3] <= WIDTH'(DLF_MR_RST);
            rd_r     <= '0;
        end else begin
            if (wr_en) begin
                mem_r[wr_idx] <= wr_data;
            end
            rd_r <= mem_r[rd_idx];  // read data from a register
        end
    end

    assign rd_data = rd_r;
endmodule : dlf_mode_mem
`default_nettype wire

// [dlf_top.sv]
// dlf_top: dram dll on/off mode, read strobe timing and clock ignore
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dlf_top
    import dlf_pkg::*;
#(
    parameter int SCHED_W = 32
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire dlf_pins_t   DRAM_PINS,
    output logic             STROBE,
    output logic             DATA_VALID,
    output logic             DLL_LOCKED,
    output logic             CLOCK_IGNORED,
    output logic             LAT_UNSUPPORTED,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    // ========================================================
    // pin synchronisers, second stage is the only reader of the first
    dlf_pins_t pins_s1_r, pins_r, pins_d_r;
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pins_s1_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            pins_r    <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            pins_d_r  <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
        end else begin
            pins_s1_r <= DRAM_PINS;
            pins_r    <= pins_s1_r;
            pins_d_r  <= pins_r;
        end
    end

    // command decode: {ras_n,cas_n,we_n} with chip select low
    function automatic logic cmd_is(input dlf_pins_t p, input logic [2:0] code);
        return !p.cs_n && ({p.ras_n, p.cas_n, p.we_n} == code);
    endfunction

    // ========================================================
    // device state registers
    dlf_dll_state_t       dll_r, dll_nxt;
    logic [15:0]          lock_cnt_r, lock_cnt_nxt;
    logic [15:0]          hold_cnt_r, hold_cnt_nxt;
    logic                 sr_r, sr_nxt, pd_r, pd_nxt;
    logic                 ign_r, ign_nxt;
    logic                 dis_r, dis_nxt;
    logic [4:0]           cl_r, cl_nxt, cwl_r, cwl_nxt;
    logic [1:0]           alc_r, alc_nxt;
    logic [SCHED_W-1:0]   sched_r, sched_nxt;
    logic                 unsup_r, unsup_nxt;
    logic [15:0]          lock_cfg_r, hold_cfg_r;
    logic                 mrs, rd_cmd, sre, cke_rise, cke_fall;
    logic [4:0]           al, lat;

    assign cke_rise = pins_r.cke && !pins_d_r.cke;
    assign cke_fall = !pins_r.cke && pins_d_r.cke;
    // ignored clock means ignored commands
    assign mrs    = !ign_r && pins_r.cke && cmd_is(pins_r, 3'h0);
    assign rd_cmd = !ign_r && pins_r.cke && cmd_is(pins_r, 3'h5);
    assign sre    = cke_fall && cmd_is(pins_r, 3'h1);
    // additive latency code: off, cl-1, cl-2, reserved as off
    assign al = (alc_r == 2'h1) ? cl_r - 5'h01 :
                (alc_r == 2'h2) ? cl_r - 5'h02 : 5'h00;
    assign lat = al + cl_r - {4'h0, dis_r};

    // next device state
    always_comb begin
        dll_nxt      = dll_r;
        lock_cnt_nxt = lock_cnt_r;
        hold_cnt_nxt = hold_cnt_r;
        sr_nxt       = sr_r;
        pd_nxt       = pd_r;
        ign_nxt      = ign_r;
        dis_nxt      = dis_r;
        cl_nxt       = cl_r;
        cwl_nxt      = cwl_r;
        alc_nxt      = alc_r;
        sched_nxt    = sched_r >> 1;
        // power state: self-refresh or power-down on cke fall
        if (sre) begin
            sr_nxt       = 1'b1;
            hold_cnt_nxt = hold_cfg_r;
        end else if (cke_fall) begin
            pd_nxt       = 1'b1;
            hold_cnt_nxt = hold_cfg_r;
        end else if (cke_rise) begin
            sr_nxt  = 1'b0;
            pd_nxt  = 1'b0;
            ign_nxt = 1'b0;
        end else if ((sr_r || pd_r) && !ign_r) begin
            if (hold_cnt_r <= 16'h0001) begin
                ign_nxt = 1'b1;
            end else begin
                hold_cnt_nxt = hold_cnt_r - 16'h0001;
            end
        end
        if (mrs && pins_r.ba == 2'h1) begin
            dis_nxt = pins_r.addr[DLF_MR1_DLL_DIS];
            alc_nxt = pins_r.addr[DLF_MR1_AL_LSB +: 2];
        end
        if (mrs && pins_r.ba == 2'h0) begin
            cl_nxt = {2'h0, pins_r.addr[DLF_MR0_CL_LSB +: 3]} + DLF_CL_BIAS;
        end
        if (mrs && pins_r.ba == 2'h2) begin
            cwl_nxt = {2'h0, pins_r.addr[DLF_MR2_CWL_LSB +: 3]} + DLF_CWL_BIAS;
        end
        // dll lock sequencing
        case (dll_r)
            DLF_OFF: begin
                if (mrs && pins_r.ba == 2'h1 && !pins_r.addr[DLF_MR1_DLL_DIS]) begin
                    dll_nxt = DLF_UNLOCKED;
                end
            end
            DLF_LOCKING: begin
                if (lock_cnt_r <= 16'h0001) begin
                    dll_nxt = DLF_LOCKED;
                end else begin
                    lock_cnt_nxt = lock_cnt_r - 16'h0001;
                end
            end
            DLF_UNLOCKED, DLF_LOCKED: begin
            end
            default: dll_nxt = DLF_OFF;
        endcase
        if (dll_r != DLF_OFF && mrs && pins_r.ba == 2'h0 && pins_r.addr[DLF_MR0_DLL_RST]) begin
            dll_nxt      = DLF_LOCKING;
            lock_cnt_nxt = lock_cfg_r;
        end
        // disable wins over any lock progress
        if (mrs && pins_r.ba == 2'h1 && pins_r.addr[DLF_MR1_DLL_DIS]) begin
            dll_nxt = DLF_OFF;
        end
        // schedule strobe launch lat cycles after read
        if (rd_cmd && lat != 5'h00 && 32'(lat) <= SCHED_W) begin
            sched_nxt[lat - 5'h01] = 1'b1;
        end
        // only the six/six pair is supported when off
        unsup_nxt = dis_r && (cl_r != DLF_OFF_CL || cwl_r != DLF_OFF_CWL);
    end

    // register device state
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            dll_r      <= DLF_UNLOCKED;
            lock_cnt_r <= '0;
            hold_cnt_r <= '0;
            sr_r       <= 1'b0;
            pd_r       <= 1'b0;
            ign_r      <= 1'b0;
            dis_r      <= 1'b0;
            cl_r       <= DLF_OFF_CL;
            cwl_r      <= DLF_OFF_CWL;
            alc_r      <= 2'h0;
            sched_r    <= '0;
            unsup_r    <= 1'b0;
        end else begin
            dll_r      <= dll_nxt;
            lock_cnt_r <= lock_cnt_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            sr_r       <= sr_nxt;
            pd_r       <= pd_nxt;
            ign_r      <= ign_nxt;
            dis_r      <= dis_nxt;
            cl_r       <= cl_nxt;
            cwl_r      <= cwl_nxt;
            alc_r      <= alc_nxt;
            sched_r    <= sched_nxt;
            unsup_r    <= unsup_nxt;
        end
    end

    // data valid shares the strobe timing in both modes
    assign STROBE          = sched_r[0];
    assign DATA_VALID      = sched_r[0];
    assign DLL_LOCKED      = (dll_r == DLF_LOCKED);
    assign CLOCK_IGNORED   = ign_r;
    assign LAT_UNSUPPORTED = unsup_r;

    // ========================================================
    // mode register copy for software readback
    logic [12:0] mr_rd;
    logic [1:0]  mr_idx_r, mr_idx_nxt;
    dlf_mode_mem #(.WIDTH(13)) u_mem (
        .clk     (REF_CLK),
        .rst     (RST),
        .wr_en   (mrs),
        .wr_idx  (pins_r.ba),
        .wr_data (pins_r.addr),
        .rd_idx  (mr_idx_nxt),  // index ahead so data is ready for pend
        .rd_data (mr_rd)
    );

    // ========================================================
    // axi4-lite write channel
    logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic        bv_r, bv_nxt;
    logic [1:0]  br_r, br_nxt;
    logic [7:0]  wa_r, wa_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic [15:0] lock_cfg_nxt, hold_cfg_nxt;

    always_comb begin
        aw_got_nxt   = aw_got_r;
        w_got_nxt    = w_got_r;
        bv_nxt       = bv_r;
        br_nxt       = br_r;
        wa_nxt       = wa_r;
        wd_nxt       = wd_r;
        lock_cfg_nxt = lock_cfg_r;
        hold_cfg_nxt = hold_cfg_r;
        if (S_AXI_AWVALID && !aw_got_r && !bv_r) begin
            aw_got_nxt = 1'b1;
            wa_nxt     = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !w_got_r && !bv_r) begin
            w_got_nxt = 1'b1;
            wd_nxt    = S_AXI_WDATA;
        end
        // write performed once both halves are held
        if (aw_got_r && w_got_r) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bv_nxt     = 1'b1;
            br_nxt     = DLF_RESP_OK;
            case (wa_r)
                DLF_LOCK_CFG_OFS: lock_cfg_nxt = wd_r[15:0];
                DLF_HOLD_CFG_OFS: hold_cfg_nxt = wd_r[15:0];
                default:          br_nxt = DLF_RESP_SLVERR;
            endcase
        end else if (bv_r && S_AXI_BREADY) begin
            bv_nxt = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            aw_got_r   <= 1'b0;
            w_got_r    <= 1'b0;
            bv_r       <= 1'b0;
            br_r       <= DLF_RESP_OK;
            wa_r       <= '0;
            wd_r       <= '0;
            lock_cfg_r <= DLF_LOCK_CYC_RST;
            hold_cfg_r <= DLF_HOLD_CYC_RST;
        end else begin
            aw_got_r   <= aw_got_nxt;
            w_got_r    <= w_got_nxt;
            bv_r       <= bv_nxt;
            br_r       <= br_nxt;
            wa_r       <= wa_nxt;
            wd_r       <= wd_nxt;
            lock_cfg_r <= lock_cfg_nxt;
            hold_cfg_r <= hold_cfg_nxt;
        end
    end

    assign S_AXI_AWREADY = !aw_got_r && !bv_r;
    assign S_AXI_WREADY  = !w_got_r && !bv_r;
    assign S_AXI_BVALID  = bv_r;
    assign S_AXI_BRESP   = br_r;

    // ========================================================
    // axi4-lite read channel: address, one wait cycle, data
    logic        ar_rdy_r, ar_rdy_nxt, pend_r, pend_nxt, rv_r, rv_nxt;
    logic [7:0]  ra_r, ra_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [1:0]  rr_r, rr_nxt;
    logic [31:0] status;

    assign status = {24'h0, pins_r.termination_control_pin, unsup_r, ign_r, pd_r, sr_r, dll_r, dis_r};

    always_comb begin
        ar_rdy_nxt = ar_rdy_r;
        pend_nxt   = 1'b0;
        rv_nxt     = rv_r;
        ra_nxt     = ra_r;
        rd_nxt     = rd_r;
        rr_nxt     = rr_r;
        mr_idx_nxt = mr_idx_r;
        if (ar_rdy_r && S_AXI_ARVALID) begin
            ar_rdy_nxt = 1'b0;
            pend_nxt   = 1'b1;
            ra_nxt     = S_AXI_ARADDR;
            mr_idx_nxt = S_AXI_ARADDR[3:2];
        end
        if (pend_r) begin
            rv_nxt = 1'b1;
            rr_nxt = DLF_RESP_OK;
            case (ra_r)
                DLF_LOCK_CFG_OFS: rd_nxt = {16'h0, lock_cfg_r};
                DLF_STATUS_OFS:   rd_nxt = status;
                DLF_HOLD_CFG_OFS: rd_nxt = {16'h0, hold_cfg_r};
                default: begin
                    if (ra_r[7:4] == DLF_MR_BASE_OFS[7:4] && ra_r[1:0] == 2'h0) begin
                        rd_nxt = {19'h0, mr_rd};
                    end else begin
                        rd_nxt = 32'h0;
                        rr_nxt = DLF_RESP_SLVERR;
                    end
                end
            endcase
        end else if (rv_r && S_AXI_RREADY) begin
            rv_nxt     = 1'b0;
            ar_rdy_nxt = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ar_rdy_r <= 1'b1;
            pend_r   <= 1'b0;
            rv_r     <= 1'b0;
            ra_r     <= '0;
            rd_r     <= '0;
            rr_r     <= DLF_RESP_OK;
            mr_idx_r <= 2'h0;
        end else begin
            ar_rdy_r <= ar_rdy_nxt;
            pend_r   <= pend_nxt;
            rv_r     <= rv_nxt;
            ra_r     <= ra_nxt;
            rd_r     <= rd_nxt;
            rr_r     <= rr_nxt;
            mr_idx_r <= mr_idx_nxt;
        end
    end

    assign S_AXI_ARREADY = ar_rdy_r;
    assign S_AXI_RVALID  = rv_r;
    assign S_AXI_RDATA   = rd_r;
    assign S_AXI_RRESP   = rr_r;

    // ========================================================
    // assertions
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    dll_off_a: assert property (mrs && pins_r.ba == 2'h1 && pins_r.addr[0] |=>
        dll_r == DLF_OFF && dis_r) else $error("dll not disabled");
    dll_on_a: assert property (dll_r == DLF_OFF && mrs && pins_r.ba == 2'h1
        && !pins_r.addr[0] |=> dll_r == DLF_UNLOCKED) else $error("dll not re-enabled");
    lat_pair_a: assert property (dis_r && cl_r == 5'h06 && cwl_r == 5'h06
        && $stable(dis_r) |=> !LAT_UNSUPPORTED) else $error("six/six flagged");
    strobe_off_a: assert property (rd_cmd && dis_r && lat == 5'h05
        |-> !STROBE [*1] ##5 STROBE) else $error("dll off strobe late");
    strobe_on_a: assert property (rd_cmd && !dis_r && lat == 5'h06
        |-> ##6 STROBE) else $error("dll on strobe late");
    data_pair_a: assert property (STROBE == DATA_VALID)
        else $error("strobe and data split");
    ign_cause_a: assert property ($rose(CLOCK_IGNORED) |-> sr_r || pd_r)
        else $error("clock ignored outside low power");
    ign_cmd_a: assert property (ign_r && !pins_r.cke |=> $stable(dll_r) && $stable(dis_r))
        else $error("command taken while clock ignored");
    lock_done_a: assert property (dll_r == DLF_LOCKING && lock_cnt_r == 16'h0001
        && !mrs |=> DLL_LOCKED) else $error("lock not reached");

    off_read_c: cover property (rd_cmd && dis_r ##[1:40] STROBE);
    relock_c: cover property (dll_r == DLF_LOCKING ##[1:1000] DLL_LOCKED);
    sr_ign_c: cover property (sr_r && CLOCK_IGNORED);
endmodule : dlf_top
`default_nettype wire

// [dlf_ctrl_model.sv]
// dlf_ctrl_model: memory controller stand-in driving the command pins
`timescale 1ns/100ps
`default_nettype none
module dlf_ctrl_model
    import dlf_pkg::*;
#(
    parameter int MOD_CYC = 8
) (
    input  wire logic clk,
    output var dlf_pins_t pins
);
    // ========================================================
    // idle pins
    // cke high, odt low
    initial begin
        pins = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                 ba: 2'h0, addr: 13'h0000, cke: 1'b1, termination_control_pin: 1'b0};
    end

    // one command slot, then deselect with address flipped
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic k);
        @(posedge clk);
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= c;
        pins.ba   <= b;
        pins.addr <= a;
        pins.cke  <= k;
        @(posedge clk);
        pins.cs_n <= 1'b1;
        pins.addr <= ~a;
    endtask : cmd

    // mode write from idle, counted mode delay
    task automatic mrs(input logic [1:0] b, input logic [12:0] a);
        cmd(4'h0, b, a, pins.cke);
        repeat (MOD_CYC) @(posedge clk);
    endtask : mrs

    // single read command
    task automatic rd();
        cmd(4'h5, 2'h0, 13'h0000, 1'b1);
    endtask : rd

    // self-refresh or power-down entry, cke low
    task automatic sleep(input logic sr);
        cmd(sr ? 4'h1 : 4'h7, 2'h0, 13'h0000, 1'b0);
    endtask : sleep

    // exit, cke held high for the mode delay
    task automatic wake();
        @(posedge clk);
        pins.cke <= 1'b1;
        repeat (MOD_CYC) @(posedge clk);
    endtask : wake
endmodule : dlf_ctrl_model
`default_nettype wire

// [test_dlf_top.sv]
// test_dlf_top: register and pin-level checks of the dll mode tracker
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module test_dlf_top
    import dlf_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awa = 8'h00;
    logic [7:0]  ara = 8'h00;
    logic [31:0] wd  = 32'h0;
    logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [31:0] v;
    logic [1:0]  resp;
    dlf_pins_t   pins;
    wire logic   awr, wr, bv, arr, rv, strobe, dvalid, locked, ign, unsup;
    wire logic [1:0]  br, rr;
    wire logic [31:0] rdat;
    int          failures = 0, n_checks = 0, cyc = 0, n0, n1, n2;
    localparam logic [12:0] M0[4] = '{13'h0020, 13'h0030, 13'h0020, 13'h0020};
    localparam logic [12:0] M2[4] = '{13'h0008, 13'h0008, 13'h0000, 13'h0008};
    localparam logic        EX[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    dlf_top u_dlf_top (.REF_CLK(clk), .RST(rst), .DRAM_PINS(pins), .STROBE(strobe),
        .DATA_VALID(dvalid), .DLL_LOCKED(locked), .CLOCK_IGNORED(ign),
        .LAT_UNSUPPORTED(unsup), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
    dlf_ctrl_model #(.MOD_CYC(8)) u_dlf_ctrl_model (.clk(clk), .pins(pins));

    // ========================================================
    // clock and watchdog
    // fixed in-range clock
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end

    // ========================================================
    // tasks
    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // bus write, address and data released as each is taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        r = br;
        bre <= 1'b0;
    endtask : axw

    // bus read
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        d = rdat;
        r = rr;
        rre <= 1'b0;
    endtask : axr

    // cycles from read command to strobe
    task automatic lat(output int n);
        n = 0;
        u_dlf_ctrl_model.rd();
        do begin @(posedge clk); n++; end while (!strobe && n < 60);
        `CHK(dvalid, 1'b1)
        @(posedge clk);
        `CHK(strobe, 1'b0)
    endtask : lat

    // cycles from cke fall to clock ignored
    task automatic hold(input logic sr, output int n);
        n = 0;
        u_dlf_ctrl_model.sleep(sr);
        do begin @(posedge clk); n++; end while (!ign && n < 60);
    endtask : hold

    // ========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // reset values, refused accesses
        axr(DLF_LOCK_CFG_OFS, v, resp); `CHK(v[15:0], DLF_LOCK_CYC_RST)
        axr(DLF_HOLD_CFG_OFS, v, resp); `CHK(v[15:0], DLF_HOLD_CYC_RST)
        axr(DLF_STATUS_OFS, v, resp); `CHK(v, 32'h0000_0002)
        axr(DLF_MR_BASE_OFS, v, resp); `CHK(v[12:0], DLF_MR0_RST)
        axr(8'h40, v, resp); `CHK({v, resp}, {32'h0, DLF_RESP_SLVERR})
        axw(DLF_STATUS_OFS, 32'hFF, resp); `CHK(resp, DLF_RESP_SLVERR)
        axw(DLF_LOCK_CFG_OFS, 32'h4, resp); `CHK(resp, DLF_RESP_OK)
        axw(DLF_HOLD_CFG_OFS, 32'h2, resp); `CHK(resp, DLF_RESP_OK)
        // read strobe latency: base, additive, dll off
        u_dlf_ctrl_model.mrs(2'h2, 13'h0008);
        lat(n0); `CHK(n0, 8)
        u_dlf_ctrl_model.mrs(2'h1, 13'h0008);
        lat(n1); `CHK(n1, n0 + 5)
        u_dlf_ctrl_model.mrs(2'h1, 13'h0010);
        lat(n1); `CHK(n1, n0 + 4)
        u_dlf_ctrl_model.mrs(2'h1, 13'h0001);
        lat(n2); `CHK(n2, n0 - 1)
        axr(DLF_STATUS_OFS, v, resp); `CHK(v, 32'h0000_0001)
        axr(DLF_MR_BASE_OFS + 8'h04, v, resp); `CHK(v, 32'h0000_0001)
        `CHK(locked, 1'b0)
        // latency pairs while dll off
        for (int i = 0; i < 4; i++) begin
            u_dlf_ctrl_model.mrs(2'h0, M0[i]);
            u_dlf_ctrl_model.mrs(2'h2, M2[i]);
            `CHK(unsup, EX[i])
        end
        // back on, dll reset, lock
        u_dlf_ctrl_model.mrs(2'h1, 13'h0000);
        axr(DLF_STATUS_OFS, v, resp); `CHK(v, 32'h0000_0002)
        u_dlf_ctrl_model.mrs(2'h0, 13'h0120);
        n0 = 0;
        while (!locked && n0 < 40) begin @(posedge clk); n0++; end
        `CHK(locked, 1'b1)
        axr(DLF_STATUS_OFS, v, resp); `CHK(v, 32'h0000_0006)
        // self-refresh: clock ignored, commands dropped
        hold(1'b1, n1);
        axr(DLF_STATUS_OFS, v, resp); `CHK(v[5:3], 3'b101)
        u_dlf_ctrl_model.mrs(2'h3, 13'h0004);
        u_dlf_ctrl_model.wake();
        `CHK(ign, 1'b0)
        axr(DLF_MR_BASE_OFS + 8'h0C, v, resp); `CHK(v, 32'h0)
        // power-down with longer hold count
        axw(DLF_HOLD_CFG_OFS, 32'h6, resp);
        hold(1'b0, n2); `CHK(n2, n1 + 4)
        axr(DLF_STATUS_OFS, v, resp); `CHK(v[5:3], 3'b110)
        u_dlf_ctrl_model.wake();
        `CHK(ign, 1'b0)
        give_verdict();
    end
endmodule : test_dlf_top
`default_nettype wire
